// [hdl/angle_timer_map.svh]
`ifndef ANGLE_TIMER_MAP_SVH
`define ANGLE_TIMER_MAP_SVH
// register indices as printed; byte address is four times the index
`define IDX_CTRL_A      13'h1fc0
`define IDX_CTRL_B      13'h1fc1
`define IDX_PERIOD      13'h1fc2
`define IDX_ANGLE       13'h1fc4
`define IDX_IRQ_STATUS  13'h1fd0
`define IDX_IRQ_MASK    13'h1fd1
`define IDX_RESULT_U    13'h1fd2
`define IDX_RESULT_V    13'h1fd3
`define IDX_RESULT_W    13'h1fd4
`define IDX_AMPLITUDE   13'h1fd5
`define IDX_SINE_DATA   13'h1fd6
// control a fields
`define CA_TIMER_EN     0
`define CA_CALC_EN      1
`define CA_XFER_EN      2
`define CA_MOD_SEL      3
`define CA_CLK_LO       4
`define CA_PHASE_ORDER  6
`define CA_DIRECTION    7
// control b fields
`define CB_IRQ_SRC      0
`define CB_SYNC_OFF     1
`define CB_BUSY         2
`define CB_SW_START     3
// interrupt status bits
`define IRQ_TIMER       0
`define IRQ_CALC        1
// reset values and limits
`define CTRL_A_RST      8'h00
`define PERIOD_RST      16'h0010
`define PERIOD_MIN      12'h010
`define ANGLE_MAX       9'h17f
`define ANGLE_THIRD     9'h080
`define STEP_GROUP      4'hf
`define CALC_CYCLES     4'h6
`endif

// [hdl/angle_timer_pkg.sv]
package angle_timer_pkg;
  typedef enum logic [1:0] {
    CALC_IDLE  = 2'b00,
    CALC_RUN   = 2'b01,
    CALC_STORE = 2'b10
  } calc_state_type;
endpackage

// [hdl/sine_table.sv]
`timescale 1ns/1ps
// sine table, one entry per angle step; read data registered
module sine_table #(
  parameter int DEPTH = 384,
  parameter int WIDTH = 12
) (
  // clock
  input  wire logic                     hclk,
  // write port
  input  wire logic                     wr_en,
  input  wire logic [8:0]               wr_addr,
  input  wire logic [WIDTH-1:0]         wr_data,
  // read port
  input  wire logic [8:0]               rd_addr,
  output logic      [WIDTH-1:0]         rd_data
);
  logic [WIDTH-1:0] mem [0:DEPTH-1];

  always_ff @(posedge hclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // sine_table

// [hdl/electrical_angle_timer_ctrl.sv]
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps
// Function
// RQ1 - writing one to the software start bit launches one calculation.
// RQ2 - the busy flag reads one while the calculator works.
// RQ3 - angle-synchronous starts occur only while the sync bit is zero.
// RQ4 - the interrupt source is timer period end or calculation end.
// RQ5 - software must not read-modify-write control register b.
// RQ6 - the direction bit picks up (0) or down (1) counting.
// RQ7 - phase order places V, W at U plus or minus 120 and 240 degrees.
// RQ8 - clock select picks the system clock divided by 8, 16, 32 or 64.
// RQ9 - modulation select gives two-phase (0) or three-phase (1).
// RQ10 - with transfer enabled results load the PWM compare outputs.
// RQ11 - software changes clock select only with the timer disabled.
// RQ12 - a period is (m + n/16) x 384 selected clocks, m at least 010h.
// RQ13 - per sixteen steps, m is counted 16-n times and m+1 n times.
// RQ14 - clearing the enable stops the timer and zeroes its count.
// RQ15 - angle writes above 17fh are rejected, others load the angle.
// RQ16 - with calculation enabled results are readable as compares.
// RQ17 - the angle steps once per m or m+1 count and wraps within 0 to 383.
module electrical_angle_timer_ctrl
  import angle_timer_pkg::*;
#(
  parameter int WAVE_W = 12
) (
  // bus clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // pwm compare load
  output logic      [WAVE_W-1:0] cmp_u,
  output logic      [WAVE_W-1:0] cmp_v,
  output logic      [WAVE_W-1:0] cmp_w,
  output logic                   cmp_load,
  // interrupt
  output logic                   irq
);
`include "angle_timer_map.svh"

  // bus address phase capture
  logic        wr_pend_r;
  logic [12:0] wr_idx_r;
  wire         access   = hsel & hready & htrans[1];
  wire  [12:0] acc_idx  = haddr[14:2];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 13'h0000;
    end else begin
      wr_pend_r <= access & hwrite;
      wr_idx_r  <= acc_idx;
    end
  end

  wire wr_a    = wr_pend_r && wr_idx_r == `IDX_CTRL_A;
  wire wr_b    = wr_pend_r && wr_idx_r == `IDX_CTRL_B;
  wire wr_per  = wr_pend_r && wr_idx_r == `IDX_PERIOD;
  wire wr_ang  = wr_pend_r && wr_idx_r == `IDX_ANGLE;
  wire wr_ist  = wr_pend_r && wr_idx_r == `IDX_IRQ_STATUS;
  wire wr_imk  = wr_pend_r && wr_idx_r == `IDX_IRQ_MASK;
  wire wr_amp  = wr_pend_r && wr_idx_r == `IDX_AMPLITUDE;
  // table entry lands at the current angle; keep calculation off meanwhile
  wire wr_sin  = wr_pend_r && wr_idx_r == `IDX_SINE_DATA;

  // control registers
  logic [7:0]        ctrl_a_r;
  logic [1:0]        ctrl_b_r;
  logic [15:0]       period_r;
  logic [1:0]        irq_mask_r;
  logic [WAVE_W-1:0] amp_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_a_r   <= `CTRL_A_RST;
      ctrl_b_r   <= 2'h0;
      period_r   <= `PERIOD_RST;
      irq_mask_r <= 2'h0;
      amp_r      <= '0;
    end else begin
      if (wr_a) begin
        ctrl_a_r <= hwdata[7:0];
      end
      if (wr_b) begin
        ctrl_b_r <= hwdata[1:0];
      end
      if (wr_per) begin
        period_r <= hwdata[15:0];
      end
      if (wr_imk) begin
        irq_mask_r <= hwdata[1:0];
      end
      if (wr_amp) begin
        amp_r <= hwdata[WAVE_W-1:0];
      end
    end
  end

  wire       timer_en    = ctrl_a_r[`CA_TIMER_EN];
  wire       calc_en     = ctrl_a_r[`CA_CALC_EN];
  wire       xfer_en     = ctrl_a_r[`CA_XFER_EN];
  wire       three_phase = ctrl_a_r[`CA_MOD_SEL];
  wire [1:0] clk_sel     = ctrl_a_r[`CA_CLK_LO+1:`CA_CLK_LO];
  wire       phase_rev   = ctrl_a_r[`CA_PHASE_ORDER];
  wire       count_down  = ctrl_a_r[`CA_DIRECTION];
  wire       irq_on_calc = ctrl_b_r[`CB_IRQ_SRC];
  wire       sync_off    = ctrl_b_r[`CB_SYNC_OFF];
  wire [3:0] corr_n      = period_r[15:12];
  wire [11:0] per_raw    = period_r[11:0];
  // values below the minimum are held at the minimum
  wire [11:0] per_m      = (per_raw < `PERIOD_MIN) ? `PERIOD_MIN : per_raw;

  // clock divider: timer clock is hclk / 8..64
  // RQ8 clock select divide
  logic [5:0] div_r;
  wire  [5:0] div_mask = {clk_sel == 2'b11, clk_sel[1], |clk_sel, 3'b111};
  wire        tick     = timer_en && ((div_r & div_mask) == div_mask);

  // RQ12 period step counter
  logic [12:0] cnt_r;
  logic [3:0]  grp_r;
  // RQ13 m+1 on n of sixteen
  wire         long_step = grp_r < corr_n;
  wire  [12:0] step_len  = {1'b0, per_m} + {12'h000, long_step};
  wire         step_end  = tick && (cnt_r + 13'h0001 >= step_len);
  logic [8:0]  angle_r;
  // RQ6 up or down count
  // RQ17 wrap 0 to 383
  wire  [8:0]  angle_up  = (angle_r >= `ANGLE_MAX) ? 9'h000
                                                   : angle_r + 9'h001;
  wire  [8:0]  angle_dn  = (angle_r == 9'h000) ? `ANGLE_MAX
                                               : angle_r - 9'h001;
  wire  [8:0]  angle_nxt = count_down ? angle_dn : angle_up;
  // RQ15 range checked write
  wire         ang_ok    = hwdata[8:0] <= `ANGLE_MAX && hwdata[15:9] == 7'h00;
  wire         period_end = step_end && grp_r == `STEP_GROUP;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_r   <= 6'h00;
      cnt_r   <= 13'h0000;
      grp_r   <= 4'h0;
      angle_r <= 9'h000;
    end else begin
      // RQ14 disable clears count
      if (!timer_en) begin
        div_r <= 6'h00;
        cnt_r <= 13'h0000;
        grp_r <= 4'h0;
      end else begin
        div_r <= div_r + 6'h01;
        if (step_end) begin
          cnt_r <= 13'h0000;
          grp_r <= grp_r + 4'h1;
        end else if (tick) begin
          cnt_r <= cnt_r + 13'h0001;
        end
      end
      if (wr_ang && ang_ok) begin
        angle_r <= hwdata[8:0];
      end else if (step_end) begin
        angle_r <= angle_nxt;
      end
    end
  end

  // waveform calculation
  calc_state_type state_r;
  logic [3:0]     calc_cnt_r;
  logic [8:0]     calc_ang_r;
  logic [1:0]     phase_r;
  logic [WAVE_W-1:0] res_u_r;
  logic [WAVE_W-1:0] res_v_r;
  logic [WAVE_W-1:0] res_w_r;
  wire  [WAVE_W-1:0] sine_q;
  // RQ1 software start
  wire  sw_start   = wr_b && hwdata[`CB_SW_START];
  // RQ3 angle-sync start
  wire  sync_start = step_end && !sync_off;
  wire  calc_go    = calc_en && state_r == CALC_IDLE &&
                     (sw_start || sync_start);
  wire  calc_done  = state_r == CALC_STORE;
  // RQ7 phase offsets
  wire  [8:0] off_v = phase_rev ? 9'h100 : `ANGLE_THIRD;
  wire  [8:0] off_w = phase_rev ? `ANGLE_THIRD : 9'h100;
  wire  [9:0] sum_v = {1'b0, calc_ang_r} + {1'b0, off_v};
  wire  [9:0] sum_w = {1'b0, calc_ang_r} + {1'b0, off_w};
  wire  [8:0] ang_v = (sum_v > 10'h17f) ? 9'(sum_v - 10'h180) : sum_v[8:0];
  wire  [8:0] ang_w = (sum_w > 10'h17f) ? 9'(sum_w - 10'h180) : sum_w[8:0];
  wire  [8:0] rd_ang = (phase_r == 2'd0) ? calc_ang_r :
                       (phase_r == 2'd1) ? ang_v : ang_w;
  // RQ9 two or three phase shaping
  wire  [2*WAVE_W-1:0] prod = sine_q * amp_r;
  wire  [WAVE_W-1:0] scaled = prod[2*WAVE_W-1:WAVE_W];
  wire  [WAVE_W-1:0] shaped = three_phase ? scaled : scaled >> 1;

  sine_table #(.DEPTH(384), .WIDTH(WAVE_W)) u_table (
    .hclk    (hclk),
    .wr_en   (wr_sin),
    .wr_addr (angle_r),
    .wr_data (hwdata[WAVE_W-1:0]),
    .rd_addr (rd_ang),
    .rd_data (sine_q)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r    <= CALC_IDLE;
      calc_cnt_r <= 4'h0;
      calc_ang_r <= 9'h000;
      phase_r    <= 2'd0;
      res_u_r    <= '0;
      res_v_r    <= '0;
      res_w_r    <= '0;
    end else begin
      unique case (state_r)
        CALC_IDLE: begin
          if (calc_go) begin
            state_r    <= CALC_RUN;
            calc_ang_r <= angle_r;
            calc_cnt_r <= 4'h0;
            phase_r    <= 2'd0;
          end
        end
        CALC_RUN: begin
          calc_cnt_r <= calc_cnt_r + 4'h1;
          if (calc_cnt_r[0]) begin
            unique case (phase_r)
              2'd0: res_u_r <= shaped;
              2'd1: res_v_r <= shaped;
              default: res_w_r <= shaped;
            endcase
            phase_r <= phase_r + 2'd1;
          end
          if (calc_cnt_r == `CALC_CYCLES - 4'h1) begin
            state_r <= CALC_STORE;
          end
        end
        CALC_STORE: state_r <= CALC_IDLE;
        default:    state_r <= CALC_IDLE;
      endcase
    end
  end

  // RQ2 busy flag
  wire busy = state_r != CALC_IDLE;

  // interrupt status, set beats clear
  logic [1:0] irq_st_r;
  wire  [1:0] irq_set = {calc_done, period_end};
  // RQ4 interrupt source select
  wire        irq_src = irq_on_calc ? irq_st_r[`IRQ_CALC] & irq_mask_r[1]
                                    : irq_st_r[`IRQ_TIMER] & irq_mask_r[0];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_st_r <= 2'h0;
      irq      <= 1'b0;
    end else begin
      irq_st_r <= irq_set | (irq_st_r & ~(wr_ist ? hwdata[1:0] : 2'h0));
      irq      <= irq_src;
    end
  end

  // RQ10 compare transfer
  // RQ16 results readable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_u    <= '0;
      cmp_v    <= '0;
      cmp_w    <= '0;
      cmp_load <= 1'b0;
    end else begin
      cmp_load <= calc_done && xfer_en;
      if (calc_done && xfer_en) begin
        cmp_u <= res_u_r;
        cmp_v <= res_v_r;
        cmp_w <= res_w_r;
      end
    end
  end

  // read mux; control b reads back only the busy flag and stored bits
  // RQ5 control b start bit write only
  wire [31:0] rd_mux =
    (acc_idx == `IDX_CTRL_A)     ? {24'h0, ctrl_a_r} :
    (acc_idx == `IDX_CTRL_B)     ? {29'h0, busy, ctrl_b_r} :
    (acc_idx == `IDX_PERIOD)     ? {16'h0, period_r} :
    (acc_idx == `IDX_ANGLE)      ? {23'h0, angle_r} :
    (acc_idx == `IDX_IRQ_STATUS) ? {30'h0, irq_st_r} :
    (acc_idx == `IDX_IRQ_MASK)   ? {30'h0, irq_mask_r} :
    (acc_idx == `IDX_RESULT_U)   ? 32'(res_u_r) :
    (acc_idx == `IDX_RESULT_V)   ? 32'(res_v_r) :
    (acc_idx == `IDX_RESULT_W)   ? 32'(res_w_r) :
    (acc_idx == `IDX_AMPLITUDE)  ? 32'(amp_r) : 32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (access && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end
endmodule // electrical_angle_timer_ctrl

// [bench/angle_timer_sva.sv]
`timescale 1ns/1ps
`include "angle_timer_map.svh"
module angle_timer_sva #(
  parameter int WAVE_W = 12
) (
  // bus
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              hsel,
  input wire logic [31:0]       haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [31:0]       hwdata,
  input wire logic              hready,
  input wire logic [31:0]       hrdata,
  input wire logic              hreadyout,
  input wire logic              hresp,
  // outputs
  input wire logic [WAVE_W-1:0] cmp_u,
  input wire logic [WAVE_W-1:0] cmp_v,
  input wire logic [WAVE_W-1:0] cmp_w,
  input wire logic              cmp_load,
  input wire logic              irq
);
  logic        aw_r;
  logic [12:0] ai_r;
  logic [7:0]  ca_r;
  logic [1:0]  mk_r;
  wire         tk = hsel & hready & htrans[1];
  wire         rd = tk & !hwrite;
  // shadow copies so outputs can be tied to what software wrote
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aw_r <= 1'b0;
      ai_r <= 13'h0000;
      ca_r <= 8'h00;
      mk_r <= 2'h0;
    end else begin
      if (hready) aw_r <= tk & hwrite;
      if (hready) ai_r <= haddr[14:2];
      if (aw_r && ai_r == `IDX_CTRL_A) ca_r <= hwdata[7:0];
      if (aw_r && ai_r == `IDX_IRQ_MASK) mk_r <= hwdata[1:0];
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_load_pulse: assert property (cmp_load |=> !cmp_load)
    else $error("compare load wider than one cycle");
  a_load_gated: assert property (cmp_load |-> ca_r[2] && ca_r[1])
    else $error("compare load while transfer disabled");
  a_cmp_hold: assert property (
    !cmp_load |-> $stable({cmp_u, cmp_v, cmp_w}))
    else $error("compare value moved without load");
  a_ctrl_back: assert property (
    rd && haddr[14:2] == `IDX_CTRL_A |=> hrdata[7:0] == ca_r)
    else $error("control a read back differs");
  a_start_zero: assert property (
    rd && haddr[14:2] == `IDX_CTRL_B |=> !hrdata[3])
    else $error("start bit reads one");
  a_angle_range: assert property (
    rd && haddr[14:2] == `IDX_ANGLE |=> hrdata[15:0] <= 16'h017f)
    else $error("angle out of range");
  a_mask_off: assert property (mk_r == 2'h0 [*3] |-> !irq)
    else $error("interrupt while masked");
  a_bus_ready: assert property (hreadyout && !hresp)
    else $error("wait state or error response");
endmodule // angle_timer_sva
bind electrical_angle_timer_ctrl angle_timer_sva #(.WAVE_W(WAVE_W)) u_sva (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hrdata, .hreadyout, .hresp, .cmp_u, .cmp_v, .cmp_w, .cmp_load, .irq);

// [bench/pwm_compare_model.sv]
`timescale 1ns/1ps
module pwm_compare_model #(
  parameter int WAVE_W = 12
) (
  // clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // compare load
  input  wire logic              cmp_load,
  input  wire logic [WAVE_W-1:0] cmp_u,
  input  wire logic [WAVE_W-1:0] cmp_v,
  input  wire logic [WAVE_W-1:0] cmp_w,
  // loads seen and duty values held
  output int                     loads,
  output logic [3*WAVE_W-1:0]    duty
);
  // duty registers take results on load
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      duty   <= '0;
      loads  <= 0;
    end else if (cmp_load) begin
      duty   <= {cmp_u, cmp_v, cmp_w};
      loads  <= loads + 1;
    end
  end
endmodule // pwm_compare_model

// [bench/electrical_angle_timer_ctrl_bench.sv]
`timescale 1ns/1ps
`include "angle_timer_map.svh"
module electrical_angle_timer_ctrl_bench;
  logic        hclk, hresetn, hsel, hwrite, rd_ph;
  logic [31:0] haddr, hwdata, rv;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  wire  [31:0] hrdata;
  wire         hready, hresp, cmp_load, irq;
  wire  [11:0] cmp_u, cmp_v, cmp_w;
  wire  [35:0] duty;
  int          n_errors, check_count, loads, seed, k, n0;
  logic [31:0] exq[$];
  electrical_angle_timer_ctrl u_dut (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout(hready), .hresp, .cmp_u, .cmp_v, .cmp_w, .cmp_load, .irq);
  pwm_compare_model u_pwm (.hclk, .hresetn, .cmp_load, .cmp_u, .cmp_v,
    .cmp_w, .loads, .duty);
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task complete_run;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task check(string nm, logic [31:0] e, logic [31:0] s);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, s);
    end
  endtask
  task xfer(logic w, logic [12:0] idx, logic [31:0] d);
    int t;
    t = 0;
    @(posedge hclk);
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {17'h0, idx, 2'b00};
    do begin @(posedge hclk); t++; end while (hready !== 1'b1 && t < 50);
    htrans <= 2'b00;
    hwdata <= d;
    do begin @(posedge hclk); t++; end while (hready !== 1'b1 && t < 50);
    if (t >= 50) begin
      n_errors++;
      complete_run;
    end
  endtask
  task wr(logic [12:0] idx, logic [31:0] d);
    xfer(1'b1, idx, d);
  endtask
  task rd(logic [12:0] idx, logic [31:0] e);
    exq.push_back(e);
    xfer(1'b0, idx, 32'h0);
  endtask
  task wait_irq(logic l, int n);
    int i;
    for (i = 0; i < n && irq !== l; i++) @(negedge hclk);
    check("irq", {31'h0, l}, {31'h0, irq});
  endtask
  task cmp3(logic [11:0] u, logic [11:0] v, logic [11:0] w);
    check("duty u", {20'h0, u}, {20'h0, duty[35:24]});
    check("duty v", {20'h0, v}, {20'h0, duty[23:12]});
    check("duty w", {20'h0, w}, {20'h0, duty[11:0]});
  endtask
  // read data stands through the data phase, so compare mid-cycle
  always @(posedge hclk) rd_ph <= hsel && htrans[1] && !hwrite && hready;
  always @(negedge hclk) begin
    if (rd_ph && hready) check("hrdata", exq.pop_front(), hrdata);
  end
  initial begin
    repeat (100000) @(posedge hclk);
    n_errors++;
    complete_run;
  end
  initial begin
    seed = 4534;
    {hsel, hwrite, htrans, haddr, hwdata, hresetn} = '0;
    hsize = 3'b010;
    hsel = 1'b1;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`IDX_CTRL_A, 32'h0);
    rd(`IDX_PERIOD, 32'h10);
    rd(13'h1fe0, 32'h0);
    // each table entry holds its own angle, so results are predictable
    for (k = 0; k < 384; k++) begin
      wr(`IDX_ANGLE, k);
      wr(`IDX_SINE_DATA, k);
    end
    wr(`IDX_AMPLITUDE, 32'h800);
    for (k = 0; k < 4; k++) begin
      wr(`IDX_CTRL_A, {24'h0, 2'b11, k[1:0], 4'h8});
      rd(`IDX_CTRL_A, {24'h0, 2'b11, k[1:0], 4'h8});
    end
    rv = $random(seed);
    wr(`IDX_PERIOD, {16'h0, rv[15:12], rv[11:0] | 12'h010});
    rd(`IDX_PERIOD, {16'h0, rv[15:12], rv[11:0] | 12'h010});
    wr(`IDX_ANGLE, 32'h17f);
    wr(`IDX_ANGLE, 32'h180);
    rd(`IDX_ANGLE, 32'h17f);
    wr(`IDX_PERIOD, 32'h10);
    // a step is 16 timer clocks of 8 or 16 hclk; read lands in step two
    for (k = 0; k < 2; k++) begin
      wr(`IDX_ANGLE, 32'h0);
      wr(`IDX_CTRL_A, {24'h0, k[0], 2'b00, k[0], 4'h0});
      wr(`IDX_CTRL_A, {24'h0, k[0], 2'b00, k[0], 4'h1});
      repeat (k ? 376 : 188) @(posedge hclk);
      rd(`IDX_ANGLE, k ? 32'h17f : 32'h1);
      wr(`IDX_CTRL_A, 32'h0);
    end
    // n = 8 stretches sixteen steps from 2048 to 2112 hclk
    wr(`IDX_PERIOD, 32'h8010);
    wr(`IDX_IRQ_MASK, 32'h1);
    wr(`IDX_CTRL_B, 32'h0);
    wr(`IDX_CTRL_A, 32'h1);
    repeat (2100) @(posedge hclk);
    check("irq early", 32'h0, {31'h0, irq});
    wait_irq(1'b1, 200);
    wr(`IDX_CTRL_A, 32'h0);
    wr(`IDX_PERIOD, 32'h10);
    wr(`IDX_IRQ_STATUS, 32'h1);
    wait_irq(1'b0, 4);
    wr(`IDX_IRQ_MASK, 32'h2);
    wr(`IDX_ANGLE, 32'h20);
    wr(`IDX_CTRL_A, 32'h6);
    wr(`IDX_CTRL_B, 32'h3);
    repeat (20) @(posedge hclk);
    check("loads", 32'h0, loads);
    wr(`IDX_CTRL_B, 32'hb);
    rd(`IDX_CTRL_B, 32'h7);
    wait_irq(1'b1, 20);
    rd(`IDX_CTRL_B, 32'h3);
    check("loads", 32'h1, loads);
    cmp3(12'h08, 12'h28, 12'h48);
    wr(`IDX_IRQ_STATUS, 32'h2);
    wait_irq(1'b0, 4);
    wr(`IDX_CTRL_A, 32'h4e);
    wr(`IDX_CTRL_B, 32'hb);
    repeat (12) @(posedge hclk);
    check("loads", 32'h2, loads);
    cmp3(12'h10, 12'h90, 12'h50);
    rd(`IDX_RESULT_W, 32'h50);
    wr(`IDX_CTRL_B, 32'h1);
    wr(`IDX_CTRL_A, 32'h7);
    repeat (300) @(posedge hclk);
    check("sync loads", 32'h1, {31'h0, loads > 2});
    wr(`IDX_CTRL_B, 32'h3);
    repeat (20) @(posedge hclk);
    n0 = loads;
    repeat (300) @(posedge hclk);
    check("sync off loads", n0, loads);
    wr(`IDX_CTRL_A, 32'h0);
    wr(`IDX_IRQ_MASK, 32'h0);
    wait_irq(1'b0, 4);
    complete_run;
  end
endmodule // electrical_angle_timer_ctrl_bench
